// File: dv/ssra_core_checker.sv
// port-level assertions for the serial register access core
`timescale 1ns/1ns
module ssra_core_checker import ssra_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_upd_valid,
	input wire logic o_upd_ready,
	input wire logic o_wr_valid,
	input wire logic [ADDR_W-1:0] o_wr_addr,
	input wire logic [DATA_W-1:0] o_wr_data,
	input wire logic o_sdi,
	input wire logic o_sdi_oe,
	input wire logic o_spi_locked
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_LOCK_HOLD: assert property (o_spi_locked |=> o_spi_locked)
		else $error("spi lock dropped");
	AST_LOCK_SET: assert property ($fell(i_cs_n) |-> ##[1:8] o_spi_locked)
		else $error("chip select low did not lock");
	AST_I2C_OFF: assert property (o_spi_locked && i_cs_n |-> !o_sdi_oe)
		else $error("data pin driven while deselected and locked");
	AST_OPEN_DRAIN: assert property (o_sdi_oe && !o_spi_locked |-> !o_sdi)
		else $error("i2c data pin driven high");
	AST_UPD_TAKE: assert property (i_upd_valid && o_upd_ready |=> !o_upd_ready)
		else $error("update not taken");
	AST_UPD_DONE: assert property ($fell(o_upd_ready) |-> ##[1:200] o_upd_ready)
		else $error("update never finished");
	AST_WR_GAP: assert property (o_wr_valid |=> !o_wr_valid [*3])
		else $error("write reports too close");
	AST_WR_HOLD: assert property (!o_wr_valid |-> $stable(o_wr_addr) && $stable(o_wr_data))
		else $error("write report changed without pulse");
	COV_WR: cover property (o_wr_valid);
	COV_LOCK: cover property ($rose(o_spi_locked));
	COV_3W: cover property (o_sdi_oe && o_spi_locked);
endmodule
bind ssra_core ssra_core_checker u_chk (.i_clk, .i_rst, .i_cs_n, .i_upd_valid, .o_upd_ready,
	.o_wr_valid, .o_wr_addr, .o_wr_data, .o_sdi, .o_sdi_oe, .o_spi_locked);

// File: dv/ssra_host_model.sv
// host model: mode-3 spi and i2c master on the link pins
`timescale 1ns/1ns
module ssra_host_model (
	input wire logic i_line,
	input wire logic i_out,
	input wire logic i_sel_out,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_d
);
	initial begin
		o_sck = 1'b1;
		o_cs_n = 1'b1;
		o_d = 1'b1;
	end
	task automatic bitx(input logic b, output logic q);
		o_sck = 1'b0;
		#1;
		o_d = b;
		#31;
		o_sck = 1'b1;
		q = i_sel_out ? i_out : i_line;
		// bench bit time is shorter than a real host may use; logic keeps no timing
		#32;
	endtask
	task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
	endtask
	task automatic idle(input int n);
		logic q;
		repeat (n) bitx(1'b1, q);
	endtask
	task automatic sel(input logic v);
		#16;
		o_cs_n = v;
		#16;
		o_d = 1'b1;
	endtask
	task automatic start();
		idle(1);
		o_d = 1'b0;
		#32;
	endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the serial register access core
`timescale 1ns/1ns
module tb;
	import ssra_pkg::*;
	logic i_clk, i_rst, i_irq, i_upd_valid;
	logic [ADDR_W-1:0] i_upd_addr;
	logic [DATA_W-1:0] i_upd_data;
	logic sck, cs_n, hd, sdi, sdi_oe, so, so_oe, upd_ready, wr_valid, locked;
	logic sel_out = 1'b0;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [7:0] a, b, c, d, q;
	logic [14:0] exp_q[$];
	int errors = 0;
	int check_count = 0;
	// open-drain data line and pulled-up shared pin
	wire line = hd & (sdi_oe ? sdi : 1'b1);
	wire pin = so_oe ? so : 1'b1;
	ssra_core u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(line),
		.o_sdi(sdi), .o_sdi_oe(sdi_oe), .i_serial_out_irq_pin(pin), .o_serial_out_irq_pin(so),
		.o_serial_out_irq_pin_oe(so_oe), .i_irq(i_irq), .i_upd_valid(i_upd_valid),
		.i_upd_addr(i_upd_addr), .i_upd_data(i_upd_data), .o_upd_ready(upd_ready),
		.o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_spi_locked(locked));
	ssra_host_model h (.i_line(line), .i_out(pin), .i_sel_out(sel_out), .o_sck(sck),
		.o_cs_n(cs_n), .o_d(hd));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		if (wr_valid === 1'b1) begin
			chk({wr_addr, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 15'h7FFF);
		end
	end
	task automatic i2c_tx(input logic [7:0] v, input logic ack);
		logic k;
		h.byte_x(v, q);
		h.bitx(1'b1, k);
		chk({14'h0, k}, {14'h0, ack});
	endtask
	task automatic i2c_rx(input logic [7:0] e, input logic ack);
		logic k;
		h.byte_x(8'hFF, q);
		h.bitx(ack, k);
		chk({7'h0, q}, {7'h0, e});
	endtask
	task automatic spi_wr(input logic [6:0] ad, input logic [7:0] v);
		exp_q.push_back({ad, v});
		h.sel(1'b0);
		h.byte_x({1'b0, ad}, q);
		h.byte_x(v, q);
		h.sel(1'b1);
	endtask
	task automatic spi_rd(input logic [6:0] ad, input logic [7:0] e[$]);
		h.sel(1'b0);
		h.byte_x({RW_READ, ad}, q);
		foreach (e[i]) begin
			h.byte_x(8'hFF, q);
			chk({7'h0, q}, {7'h0, e[i]});
		end
		h.sel(1'b1);
	endtask
	initial begin
		#1000000;
		errors++;
		results();
	end
	initial begin
		i_rst <= 1'b1;
		i_irq <= 1'b0;
		i_upd_valid <= 1'b0;
		i_upd_addr <= '0;
		i_upd_data <= '0;
		void'($urandom(77752));
		a = 8'($urandom);
		b = 8'($urandom);
		c = 8'($urandom);
		d = 8'($urandom);
		// link side needs its own clock edges to leave reset
		fork
			h.idle(20);
			begin
				repeat (3) @(posedge i_clk);
				i_rst <= 1'b0;
				repeat (12) @(posedge i_clk);
			end
		join
		exp_q.push_back({7'h20, a});
		exp_q.push_back({7'h21, b});
		h.start();
		i2c_tx(8'hEC, 1'b1);
		h.start();
		i2c_tx({I2C_ADDR_HIGH, 1'b0}, 1'b0);
		i2c_tx(8'h20, 1'b0);
		i2c_tx(a, 1'b0);
		i2c_tx(b, 1'b0);
		h.start();
		i2c_tx({I2C_ADDR_HIGH, 1'b0}, 1'b0);
		i2c_tx(8'h20, 1'b0);
		h.start();
		i2c_tx({I2C_ADDR_HIGH, RW_READ}, 1'b0);
		i2c_rx(a, 1'b0);
		i2c_rx(b, 1'b1);
		$display("test i2c done");
		@(posedge i_clk);
		i_upd_addr <= 7'h22;
		i_upd_data <= c;
		i_upd_valid <= 1'b1;
		@(posedge i_clk);
		i_upd_valid <= 1'b0;
		#1;
		chk({14'h0, upd_ready}, 15'h0);
		h.idle(20);
		repeat (4) @(posedge i_clk);
		chk({14'h0, upd_ready}, 15'h1);
		$display("test update done");
		sel_out = 1'b1;
		spi_rd(7'h20, '{a, b, c});
		chk({14'h0, locked}, 15'h1);
		spi_wr(7'h23, d);
		sel_out = 1'b0;
		h.start();
		i2c_tx({I2C_ADDR_HIGH, 1'b0}, 1'b1);
		$display("test spi done");
		spi_wr(CFG_ADDR, 8'h70);
		@(posedge i_clk);
		i_irq <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk({14'h0, so_oe}, 15'h0);
		spi_wr(CFG_ADDR, 8'hF1);
		repeat (10) @(posedge i_clk);
		chk({13'h0, so_oe, so}, 15'h3);
		spi_rd(7'h23, '{d});
		$display("test irq done");
		repeat (10) @(posedge i_clk);
		chk({14'h0, exp_q.size() == 0}, 15'h1);
		results();
	end
endmodule

// File: rtl/ssra_core.sv
// i2c slave and mode-3 spi slave giving a host access to one shared register image
// Contract
// - every register is readable and writable over either i2c or spi.
// - spi runs only in mode 3, clock idles high; host must use it.
// - spi offers single write, single read and auto-increment burst read.
// - chip select high selects i2c, chip select low selects spi.
// - first chip select low disables i2c until the next power-on reset.
// - i2c accepts standard, fast and high-speed bus rates.
// - i2c address 0x77 with shared pin high or floating, 0x76 when low.
// - i2c reads and writes auto-increment the address until stop.
// - spi starts 4-wire, becomes 3-wire after config bit written 1.
// - spi write: control byte bit7 zero plus address, data, chip select ends.
// - spi read: control byte bit7 one plus address, data until deselect.
// - read data leaves on out pin (4-wire) or data pin (3-wire), incrementing.
// - in i2c and 3-wire spi the out pin may carry the interrupt.
// - no interrupt on the out pin in 4-wire spi.
`timescale 1ns/1ns
module ssra_core import ssra_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	output logic o_sdi,
	output logic o_sdi_oe,
	input wire logic i_serial_out_irq_pin,
	output logic o_serial_out_irq_pin,
	output logic o_serial_out_irq_pin_oe,
	input wire logic i_irq,
	input wire logic i_upd_valid,
	input wire logic [ADDR_W-1:0] i_upd_addr,
	input wire logic [DATA_W-1:0] i_upd_data,
	output logic o_upd_ready,
	output logic o_wr_valid,
	output logic [ADDR_W-1:0] o_wr_addr,
	output logic [DATA_W-1:0] o_wr_data,
	output logic o_spi_locked
);
	// link domain, rising edge of the serial clock
	typedef struct packed {
		ssra_i2c_state_t st;
		logic [2:0] bcnt;
		logic [DATA_W-1:0] sh;
		logic [ADDR_W-1:0] ptr;
		logic sda_pos;
		logic lock;
		logic [DATA_W-1:0] cfg;
		logic upd_ack;
		logic wr_tgl;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
	} ssra_link_t;
	// spi frame state, cleared by the frame's own deselect
	typedef struct packed {
		logic [2:0] bcnt;
		logic [DATA_W-1:0] sh;
		logic ctl_done;
		logic is_read;
		logic wr_done;
		logic [ADDR_W-1:0] addr;
	} ssra_spi_t;
	// link domain, falling edge: every link-side pin driver (the interrupt level and enable come from the system clock domain)
	typedef struct packed {
		logic start_seen;
		logic i2c_low;
		logic spi_oe;
		logic dout;
	} ssra_neg_t;
	// system clock domain
	typedef struct packed {
		logic lock;
		logic [2:0] strap_cnt;
		logic strap;
		logic strap_done;
		logic upd_busy;
		logic upd_tgl;
		logic [ADDR_W-1:0] upd_addr;
		logic [DATA_W-1:0] upd_data;
		logic wr_seen;
		logic wr_valid;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
		logic irq_lvl;
		logic irq_oe;
	} ssra_sys_t;

	ssra_link_t lnk_reg, lnk_next;
	ssra_spi_t spi_reg, spi_next;
	ssra_neg_t neg_reg, neg_next;
	ssra_sys_t sys_reg, sys_next;
	logic [DATA_W-1:0] img_mem [IMG_DEPTH];
	logic [2:0] lsync;
	logic lrst, l_upd, l_strap;
	logic [6:0] ssync;
	logic s_cs_n, s_sdo, s_upd_ack, s_wr, s_int_hl, s_int_en, s_spi3;
	logic spi3, i2c_en, spi_wr, i2c_wr, host_wr, upd_wr, sdi_spi_drv, sdo_spi_drv;
	logic [ADDR_W-1:0] my_addr, wa;
	logic [DATA_W-1:0] spi_byte, i2c_byte, spi_rd, i2c_rd, wd;

	// link side needs the serial clock running through reset to see it
	ssra_sync #(.W(3), .RST_VAL(3'h4)) u_lsync (
		.i_clk(i_sck),
		.i_rst(i_rst),
		.i_d({i_rst, sys_reg.upd_tgl, sys_reg.strap}),
		.o_q(lsync)
	);
	assign lrst = lsync[2];
	assign l_upd = lsync[1];
	assign l_strap = lsync[0];

	ssra_sync #(.W(7), .RST_VAL(7'h60)) u_ssync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_cs_n, i_serial_out_irq_pin, lnk_reg.upd_ack, lnk_reg.wr_tgl,
			lnk_reg.cfg[CFG_INT_HL], |lnk_reg.cfg[CFG_SEL_MSB:CFG_SEL_LSB],
			lnk_reg.cfg[CFG_SPI3]}),
		.o_q(ssync)
	);
	assign {s_cs_n, s_sdo, s_upd_ack, s_wr, s_int_hl, s_int_en, s_spi3} = ssync;

	assign spi3 = lnk_reg.cfg[CFG_SPI3];
	assign i2c_en = i_cs_n & ~lnk_reg.lock;
	assign my_addr = l_strap ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
	assign spi_byte = {spi_reg.sh[DATA_W-2:0], i_sdi};
	assign i2c_byte = {lnk_reg.sh[DATA_W-2:0], i_sdi};
	// configuration byte lives in flops so it has a reset value
	assign spi_rd = (spi_reg.addr == CFG_ADDR) ? lnk_reg.cfg : img_mem[spi_reg.addr];
	assign i2c_rd = (lnk_reg.ptr == CFG_ADDR) ? lnk_reg.cfg : img_mem[lnk_reg.ptr];

	// only the first data byte of a spi write lands
	assign spi_wr = ~i_cs_n & spi_reg.ctl_done & ~spi_reg.is_read & ~spi_reg.wr_done
		& (spi_reg.bcnt == LAST_BIT);
	assign i2c_wr = i2c_en & (lnk_reg.st == I2C_WDATA) & (lnk_reg.bcnt == LAST_BIT);
	assign host_wr = (spi_wr | i2c_wr) & ~lrst;
	// system updates wait behind host writes; the link is idle most of the time
	assign upd_wr = (l_upd != lnk_reg.upd_ack) & ~host_wr & ~lrst;
	assign wa = spi_wr ? spi_reg.addr : (i2c_wr ? lnk_reg.ptr : sys_reg.upd_addr);
	assign wd = spi_wr ? spi_byte : (i2c_wr ? i2c_byte : sys_reg.upd_data);

	always_ff @(posedge i_sck) begin
		if (host_wr | upd_wr) begin
			img_mem[wa] <= wd;
		end
	end

	always_comb begin
		lnk_next = lnk_reg;
		lnk_next.sda_pos = i_sdi;
		if (~i_cs_n) begin
			lnk_next.lock = 1'b1;
		end
		if ((host_wr | upd_wr) && (wa == CFG_ADDR)) begin
			lnk_next.cfg = wd;
		end
		if (host_wr) begin
			lnk_next.wr_tgl = ~lnk_reg.wr_tgl;
			lnk_next.wr_addr = wa;
			lnk_next.wr_data = wd;
		end
		if (upd_wr) begin
			lnk_next.upd_ack = l_upd;
		end
		if (~i2c_en) begin
			lnk_next.st = I2C_IDLE;
		end else if (neg_reg.start_seen) begin
			lnk_next.st = I2C_ADDR;
			lnk_next.bcnt = BIT_STEP;
			lnk_next.sh = {{(DATA_W-1){1'b0}}, i_sdi};
		end else begin
			case (lnk_reg.st)
				I2C_ADDR: begin
					lnk_next.sh = i2c_byte;
					lnk_next.bcnt = lnk_reg.bcnt + BIT_STEP;
					if (lnk_reg.bcnt == LAST_BIT) begin
						lnk_next.st = (i2c_byte[DATA_W-1:1] == my_addr) ? I2C_ACK_ADDR : I2C_IDLE;
					end
				end
				I2C_ACK_ADDR: begin
					lnk_next.bcnt = FIRST_BIT;
					if (lnk_reg.sh[0] == RW_READ) begin
						lnk_next.sh = i2c_rd;
						lnk_next.ptr = lnk_reg.ptr + ADDR_STEP;
						lnk_next.st = I2C_RDATA;
					end else begin
						lnk_next.st = I2C_PTR;
					end
				end
				I2C_PTR: begin
					lnk_next.sh = i2c_byte;
					lnk_next.bcnt = lnk_reg.bcnt + BIT_STEP;
					if (lnk_reg.bcnt == LAST_BIT) begin
						lnk_next.ptr = i2c_byte[ADDR_W-1:0];
						lnk_next.st = I2C_ACK_W;
					end
				end
				I2C_ACK_W: begin
					lnk_next.bcnt = FIRST_BIT;
					lnk_next.st = I2C_WDATA;
				end
				I2C_WDATA: begin
					lnk_next.sh = i2c_byte;
					lnk_next.bcnt = lnk_reg.bcnt + BIT_STEP;
					if (lnk_reg.bcnt == LAST_BIT) begin
						lnk_next.ptr = lnk_reg.ptr + ADDR_STEP;
						lnk_next.st = I2C_ACK_W;
					end
				end
				I2C_RDATA: begin
					lnk_next.sh = {lnk_reg.sh[DATA_W-2:0], 1'b0};
					lnk_next.bcnt = lnk_reg.bcnt + BIT_STEP;
					if (lnk_reg.bcnt == LAST_BIT) begin
						lnk_next.st = I2C_RACK;
					end
				end
				I2C_RACK: begin
					lnk_next.bcnt = FIRST_BIT;
					if (~i_sdi) begin
						lnk_next.sh = i2c_rd;
						lnk_next.ptr = lnk_reg.ptr + ADDR_STEP;
						lnk_next.st = I2C_RDATA;
					end else begin
						lnk_next.st = I2C_IDLE;
					end
				end
				default: begin
					lnk_next.st = I2C_IDLE;
				end
			endcase
		end
		if (lrst) begin
			lnk_next = '0;
			lnk_next.st = I2C_IDLE;
			lnk_next.sda_pos = 1'b1;
			lnk_next.cfg = CFG_RESET;
		end
	end
	// i2c follows the bus clock itself, so every bus rate is served
	always_ff @(posedge i_sck) begin
		lnk_reg <= lnk_next;
	end

	// mode 3 only: capture on the rising edge, first edge of a frame is falling
	always_comb begin
		spi_next = spi_reg;
		spi_next.sh = spi_byte;
		spi_next.bcnt = spi_reg.bcnt + BIT_STEP;
		if (spi_reg.bcnt == LAST_BIT) begin
			if (~spi_reg.ctl_done) begin
				spi_next.ctl_done = 1'b1;
				spi_next.is_read = (spi_byte[CTL_RW] == RW_READ);
				spi_next.addr = spi_byte[ADDR_W-1:0];
			end else if (spi_reg.is_read) begin
				spi_next.addr = spi_reg.addr + ADDR_STEP;
			end else begin
				spi_next.wr_done = 1'b1;
			end
		end
	end

	// the clock may stop at deselect, so the deselect itself ends the frame
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			spi_reg <= '0;
		end else begin
			spi_reg <= spi_next;
		end
	end

	always_comb begin
		// start: data fell while the clock stood high since the last rising edge
		neg_next.start_seen = i2c_en & lnk_reg.sda_pos & ~i_sdi;
		neg_next.i2c_low = i2c_en & ((lnk_reg.st == I2C_ACK_ADDR) | (lnk_reg.st == I2C_ACK_W)
			| ((lnk_reg.st == I2C_RDATA) & ~lnk_reg.sh[DATA_W-1]));
		neg_next.spi_oe = spi_reg.ctl_done & spi_reg.is_read;
		neg_next.dout = spi_rd[~spi_reg.bcnt];
		if (lrst) begin
			neg_next = '0;
		end
	end
	always_ff @(negedge i_sck) begin
		neg_reg <= neg_next;
	end
	// deselect releases the pins at once; no clock edge follows it
	assign sdi_spi_drv = neg_reg.spi_oe & ~i_cs_n & spi3;
	assign sdo_spi_drv = neg_reg.spi_oe & ~i_cs_n & ~spi3;
	assign o_sdi = neg_reg.i2c_low ? 1'b0 : neg_reg.dout;
	assign o_sdi_oe = neg_reg.i2c_low | sdi_spi_drv;
	assign o_serial_out_irq_pin = sdo_spi_drv ? neg_reg.dout : sys_reg.irq_lvl;
	assign o_serial_out_irq_pin_oe = sdo_spi_drv | sys_reg.irq_oe;

	always_comb begin
		sys_next = sys_reg;
		sys_next.wr_valid = 1'b0;
		if (~s_cs_n) begin
			sys_next.lock = 1'b1;
		end
		// strap is read only after the synchroniser has filled
		if (~sys_reg.strap_done) begin
			sys_next.strap_cnt = sys_reg.strap_cnt + STRAP_STEP;
			if (sys_reg.strap_cnt == STRAP_WAIT) begin
				sys_next.strap = s_sdo;
				sys_next.strap_done = 1'b1;
			end
		end
		if (i_upd_valid & ~sys_reg.upd_busy) begin
			sys_next.upd_busy = 1'b1;
			sys_next.upd_tgl = ~sys_reg.upd_tgl;
			sys_next.upd_addr = i_upd_addr;
			sys_next.upd_data = i_upd_data;
		end else if (sys_reg.upd_busy & (s_upd_ack == sys_reg.upd_tgl)) begin
			sys_next.upd_busy = 1'b0;
		end
		// the write bundle is held for a whole byte time, far past the sync delay
		if (s_wr != sys_reg.wr_seen) begin
			sys_next.wr_seen = s_wr;
			sys_next.wr_valid = 1'b1;
			sys_next.wr_addr = lnk_reg.wr_addr;
			sys_next.wr_data = lnk_reg.wr_data;
		end
		sys_next.irq_lvl = s_int_hl ? i_irq : ~i_irq;
		sys_next.irq_oe = sys_reg.strap_done & s_int_en & (~sys_reg.lock | s_spi3);
		if (i_rst) begin
			sys_next = '0;
		end
	end
	always_ff @(posedge i_clk) begin
		sys_reg <= sys_next;
	end
	assign o_upd_ready = ~sys_reg.upd_busy;
	assign o_wr_valid = sys_reg.wr_valid;
	assign o_wr_addr = sys_reg.wr_addr;
	assign o_wr_data = sys_reg.wr_data;
	assign o_spi_locked = sys_reg.lock;
endmodule

// File: rtl/ssra_pkg.sv
// shared constants and types of the sensor serial register access block
package ssra_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int IMG_DEPTH = 128;
	localparam logic [ADDR_W-1:0] CFG_ADDR = 7'h09;
	localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
	localparam int CFG_INT_HL = 7;
	localparam int CFG_SEL_MSB = 6;
	localparam int CFG_SEL_LSB = 4;
	localparam int CFG_SPI3 = 0;
	localparam int CTL_RW = 7;
	localparam logic RW_READ = 1'b1;
	localparam logic [ADDR_W-1:0] I2C_ADDR_HIGH = 7'h77;
	localparam logic [ADDR_W-1:0] I2C_ADDR_LOW = 7'h76;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam logic [2:0] BIT_STEP = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;
	localparam logic [2:0] STRAP_WAIT = 3'h4;
	localparam logic [2:0] STRAP_STEP = 3'h1;
	localparam real SPI_CLK_MAX_MHZ = 10.0;
	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ACK_ADDR,
		I2C_PTR,
		I2C_ACK_W,
		I2C_WDATA,
		I2C_RDATA,
		I2C_RACK
	} ssra_i2c_state_t;
endpackage

// File: rtl/ssra_sync.sv
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
module ssra_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ssra_sync_t;

	ssra_sync_t st_reg;
	ssra_sync_t st_next;
	logic [W-1:0] agreed;

	genvar b;
	for (b = 0; b < W; b++) begin : g_bit
		assign agreed[b] = (st_reg.s2[b] == st_reg.s3[b]) ? st_reg.s3[b] : st_reg.q[b];
	end

	always_comb begin
		st_next.s1 = i_d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q = agreed;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.q;
endmodule
